// >>> qmx_host_model.sv
`timescale 1ns/100ps
module qmx_host_model (
    output logic            sclkPin,
    output logic            csPinN,
    output logic      [3:0] ioPinIn,
    input  wire logic [3:0] ioPinOut
);
    // ----------------------------------------
    // Host side of the link, 160 ns clock
    // ----------------------------------------
    initial begin
        sclkPin = 1'b0;
        csPinN  = 1'b1;
        ioPinIn = 4'h5;
    end

    // Clock stands low between frames; continuous read never opened
    task automatic frame(input logic [47:0] d, input int n, input bit q, output logic [7:0] rd);
        rd = 8'h00;
        csPinN <= 1'b0;
        for (int i = 0; i < n; i += (q ? 4 : 1)) begin
            ioPinIn <= q ? d[47-i -: 4] : {~ioPinIn[3:1], d[47-i]};
            #40 sclkPin <= 1'b1;
            rd = q ? {rd[3:0], ioPinOut} : {rd[6:0], ioPinOut[1]};
            #80 sclkPin <= 1'b0;
            #40;
        end
        csPinN  <= 1'b1;
        ioPinIn <= ~ioPinIn;
        // Quiet gap so the device can act on the rising select
        #120;
    endtask
endmodule

// >>> qmx_link_if.sv
`timescale 1ns/100ps
interface qmx_link_if;
    logic       csActive;
    logic       csStart;
    logic       csEnd;
    logic       sclkRise;
    logic       sclkFall;
    logic [3:0] ioIn;

    modport drv (
        output csActive,
        output csStart,
        output csEnd,
        output sclkRise,
        output sclkFall,
        output ioIn
    );
    modport mon (
        input csActive,
        input csStart,
        input csEnd,
        input sclkRise,
        input sclkFall,
        input ioIn
    );
endinterface

// >>> qmx_link_sync.sv
`timescale 1ns/100ps
module qmx_link_sync (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    input  wire logic       sclkPin,
    input  wire logic       csPinN,
    input  wire logic [3:0] ioPinIn,
    qmx_link_if.drv         lk
);
    // ------------------------------------------------------------
    // Two-stage capture, third stage only for edge finding
    // ------------------------------------------------------------
    logic [2:0] sclkSh_r, sclkSh_nxt;
    logic [2:0] csSh_r, csSh_nxt;
    logic [3:0] ioS1_r, ioS1_nxt;
    logic [3:0] ioS2_r, ioS2_nxt;

    always_comb begin
        sclkSh_nxt = {sclkSh_r[1:0], sclkPin};
        csSh_nxt   = {csSh_r[1:0], ~csPinN};
        ioS1_nxt   = ioPinIn;
        ioS2_nxt   = ioS1_r;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sclkSh_r <= 3'h0;
            csSh_r   <= 3'h0;
            ioS1_r   <= 4'h0;
            ioS2_r   <= 4'h0;
        end else if (clkEn) begin
            sclkSh_r <= sclkSh_nxt;
            csSh_r   <= csSh_nxt;
            ioS1_r   <= ioS1_nxt;
            ioS2_r   <= ioS2_nxt;
        end
    end

    // Clock edges outside a frame are ignored
    assign lk.csActive = csSh_r[1];
    assign lk.csStart  = csSh_r[1] & ~csSh_r[2];
    assign lk.csEnd    = ~csSh_r[1] & csSh_r[2];
    assign lk.sclkRise = csSh_r[1] & sclkSh_r[1] & ~sclkSh_r[2];
    assign lk.sclkFall = csSh_r[1] & ~sclkSh_r[1] & sclkSh_r[2];
    assign lk.ioIn     = ioS2_r;
endmodule

// >>> qmx_pkg.sv
package qmx_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the bus, byte address = 4 x index)
    // ------------------------------------------------------------
    localparam int         AV_ADDR_W  = 2;
    localparam logic [1:0] IDX_PARAM  = 2'h0;
    localparam logic [1:0] IDX_CTRL   = 2'h1;
    localparam logic [1:0] IDX_STATUS = 2'h2;

    // ------------------------------------------------------------
    // Parameter word layout and reset
    // ------------------------------------------------------------
    localparam int          PARAM_W   = 10;
    localparam int          XIP_BIT   = 9;
    localparam int          ENTRY_LSB = 4;
    localparam int          ENTRY_MSB = 8;
    localparam int          EXIT_LSB  = 0;
    localparam int          EXIT_MSB  = 3;
    localparam logic [9:0]  PARAM_RST = 10'h2FF;
    localparam int          CTRL_QE_BIT = 0;

    // ------------------------------------------------------------
    // Link opcodes and volatile configuration
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_ENTER_QE  = 8'h38;
    localparam logic [7:0]  OP_ENTER_ALT = 8'h35;
    localparam logic [7:0]  OP_RD_CFG    = 8'h65;
    localparam logic [7:0]  OP_WR_CFG    = 8'h71;
    localparam logic [7:0]  OP_WR_VECR   = 8'h61;
    localparam logic [7:0]  OP_EXIT_A    = 8'hFF;
    localparam logic [7:0]  OP_EXIT_B    = 8'hF5;
    localparam logic [7:0]  OP_RST_EN    = 8'h66;
    localparam logic [7:0]  OP_RST       = 8'h99;
    localparam logic [23:0] CFG_ADDR     = 24'h800003;
    localparam int          CFG_QUAD_BIT = 6;
    localparam int          VECR_QUAD_BIT = 7;
    localparam logic [7:0]  CFG_RST      = 8'h00;
    localparam logic [7:0]  VECR_RST     = 8'hFF;
    localparam logic [4:0]  OPC_BITS     = 5'h08;
    localparam logic [4:0]  ADDR_BITS    = 5'h18;
    localparam logic [4:0]  DATA_BITS    = 5'h08;

    // ------------------------------------------------------------
    // Frame decoder states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPC  = 3'b001,
        ST_ADDR = 3'b010,
        ST_DIN  = 3'b011,
        ST_DOUT = 3'b100,
        ST_DONE = 3'b101,
        ST_SKIP = 3'b110
    } qmx_state_t;

endpackage

// >>> qmx_seq.sv
`timescale 1ns/100ps
// Contract
// - Parameter word bit 9 reports continuous-read 0-4-4 support, 1 means supported.
// - Bits 8:4 are independent entry-method flags; several may be set together.
// - All configuration changed by these sequences is volatile, lost on reset.
// - Bits 3:0 are independent exit-method flags.
module qmx_seq (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sclkPin,
    input  wire logic        csPinN,
    input  wire logic [3:0]  ioPinIn,
    output logic      [3:0]  ioPinOut,
    output logic      [3:0]  ioPinOe
);
    // ------------------------------------------------------------
    // Link front end
    // ------------------------------------------------------------
    qmx_link_if lk ();

    qmx_link_sync u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .sclkPin (sclkPin),
        .csPinN  (csPinN),
        .ioPinIn (ioPinIn),
        .lk      (lk.drv)
    );

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    logic [9:0]  param_r, param_nxt;
    logic        qe_r, qe_nxt;
    logic        waitReq_r, waitReq_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    logic [31:0] rdMux;

    qmx_pkg::qmx_state_t st_r, st_nxt;
    logic        quadMode_r, quadMode_nxt;
    logic [7:0]  cfg_r, cfg_nxt;
    logic [7:0]  vecr_r, vecr_nxt;
    logic [7:0]  op_r, op_nxt;

    always_comb begin
        rdMux = 32'h0;
        unique case (avs_address)
            qmx_pkg::IDX_PARAM:  rdMux = {22'h0, param_r};
            qmx_pkg::IDX_CTRL:   rdMux = {31'h0, qe_r};
            qmx_pkg::IDX_STATUS: rdMux = {op_r, vecr_r, cfg_r, 4'h0, st_r, quadMode_r};
            default:             rdMux = 32'h0;
        endcase
    end

    always_comb begin
        waitReq_nxt = 1'b1;
        rdData_nxt  = rdData_r;
        param_nxt   = param_r;
        qe_nxt      = qe_r;
        // One wait cycle, then the answer; read data stands while wait is low
        if ((avs_read | avs_write) && waitReq_r) begin
            waitReq_nxt = 1'b0;
            if (avs_read) begin
                rdData_nxt = rdMux;
            end
        end
        if (avs_write && !waitReq_r) begin
            if (avs_address == qmx_pkg::IDX_PARAM) begin
                if (avs_byteenable[0]) begin
                    param_nxt[7:0] = avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    param_nxt[9:8] = avs_writedata[9:8];
                end
            end
            if (avs_address == qmx_pkg::IDX_CTRL && avs_byteenable[0]) begin
                qe_nxt = avs_writedata[qmx_pkg::CTRL_QE_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            waitReq_r <= 1'b1;
            rdData_r  <= 32'h0;
            param_r   <= qmx_pkg::PARAM_RST;
            qe_r      <= 1'b0;
        end else if (clkEn) begin
            waitReq_r <= waitReq_nxt;
            rdData_r  <= rdData_nxt;
            param_r   <= param_nxt;
            qe_r      <= qe_nxt;
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata    = rdData_r;

    // ------------------------------------------------------------
    // Frame decoder and mode state
    // ------------------------------------------------------------
    logic [4:0]  bitCnt_r, bitCnt_nxt;
    logic [23:0] shift_r, shift_nxt;
    logic [7:0]  outSh_r, outSh_nxt;
    logic        rstArm_r, rstArm_nxt;
    logic [3:0]  ioOut_r, ioOut_nxt;
    logic [3:0]  ioOe_r, ioOe_nxt;
    logic [23:0] shIn;
    logic [4:0]  cntIn;
    logic [4:0]  entry;
    logic [3:0]  exitM;
    logic        addrForm;
    logic        vecrForm;

    assign entry    = param_r[qmx_pkg::ENTRY_MSB:qmx_pkg::ENTRY_LSB];
    assign exitM    = param_r[qmx_pkg::EXIT_MSB:qmx_pkg::EXIT_LSB];
    // Both register methods share 65h; the addressed form wins if advertised
    assign addrForm = entry[3] | exitM[2];
    assign vecrForm = entry[4];

    always_comb begin
        st_nxt       = st_r;
        bitCnt_nxt   = bitCnt_r;
        shift_nxt    = shift_r;
        outSh_nxt    = outSh_r;
        op_nxt       = op_r;
        quadMode_nxt = quadMode_r;
        cfg_nxt      = cfg_r;
        vecr_nxt     = vecr_r;
        rstArm_nxt   = rstArm_r;
        ioOut_nxt    = ioOut_r;
        ioOe_nxt     = ioOe_r;
        // Lane count follows the current mode
        shIn  = quadMode_r ? {shift_r[19:0], lk.ioIn} : {shift_r[22:0], lk.ioIn[0]};
        cntIn = bitCnt_r + (quadMode_r ? 5'h04 : 5'h01);
        if (lk.csStart) begin
            st_nxt     = qmx_pkg::ST_OPC;
            bitCnt_nxt = 5'h00;
            shift_nxt  = 24'h0;
            ioOe_nxt   = 4'h0;
        end else if (lk.csEnd) begin
            st_nxt     = qmx_pkg::ST_IDLE;
            ioOe_nxt   = 4'h0;
            rstArm_nxt = 1'b0;
            if (st_r == qmx_pkg::ST_DONE) begin
                unique case (op_r)
                    qmx_pkg::OP_ENTER_QE: begin
                        if ((entry[0] && qe_r) || entry[1]) begin
                            quadMode_nxt = 1'b1;
                        end
                    end
                    qmx_pkg::OP_ENTER_ALT: begin
                        if (entry[2]) begin
                            quadMode_nxt = 1'b1;
                        end
                    end
                    qmx_pkg::OP_EXIT_A: begin
                        if (exitM[0]) begin
                            quadMode_nxt = 1'b0;
                        end
                    end
                    qmx_pkg::OP_EXIT_B: begin
                        if (exitM[1]) begin
                            quadMode_nxt = 1'b0;
                        end
                    end
                    qmx_pkg::OP_RST_EN: begin
                        rstArm_nxt = 1'b1;
                    end
                    qmx_pkg::OP_RST: begin
                        // Soft reset drops every volatile setting
                        if (rstArm_r) begin
                            quadMode_nxt = 1'b0;
                            cfg_nxt      = qmx_pkg::CFG_RST;
                            vecr_nxt     = qmx_pkg::VECR_RST;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (lk.sclkRise) begin
            unique case (st_r)
                qmx_pkg::ST_OPC: begin
                    shift_nxt  = shIn;
                    bitCnt_nxt = cntIn;
                    if (cntIn == qmx_pkg::OPC_BITS) begin
                        op_nxt     = shIn[7:0];
                        bitCnt_nxt = 5'h00;
                        st_nxt     = qmx_pkg::ST_DONE;
                        if (shIn[7:0] == qmx_pkg::OP_RD_CFG) begin
                            if (addrForm) begin
                                st_nxt = qmx_pkg::ST_ADDR;
                            end else if (vecrForm) begin
                                st_nxt    = qmx_pkg::ST_DOUT;
                                outSh_nxt = vecr_r;
                            end else begin
                                st_nxt = qmx_pkg::ST_SKIP;
                            end
                        end else if (shIn[7:0] == qmx_pkg::OP_WR_CFG) begin
                            st_nxt = addrForm ? qmx_pkg::ST_ADDR : qmx_pkg::ST_SKIP;
                        end else if (shIn[7:0] == qmx_pkg::OP_WR_VECR) begin
                            st_nxt = vecrForm ? qmx_pkg::ST_DIN : qmx_pkg::ST_SKIP;
                        end
                    end
                end
                qmx_pkg::ST_ADDR: begin
                    shift_nxt  = shIn;
                    bitCnt_nxt = cntIn;
                    if (cntIn == qmx_pkg::ADDR_BITS) begin
                        bitCnt_nxt = 5'h00;
                        if (shIn != qmx_pkg::CFG_ADDR) begin
                            st_nxt = qmx_pkg::ST_SKIP;
                        end else if (op_r == qmx_pkg::OP_RD_CFG) begin
                            st_nxt    = qmx_pkg::ST_DOUT;
                            outSh_nxt = cfg_r;
                        end else begin
                            st_nxt = qmx_pkg::ST_DIN;
                        end
                    end
                end
                qmx_pkg::ST_DIN: begin
                    shift_nxt  = shIn;
                    bitCnt_nxt = cntIn;
                    if (cntIn == qmx_pkg::DATA_BITS) begin
                        // Extra data bytes in the frame are dropped
                        st_nxt = qmx_pkg::ST_SKIP;
                        if (op_r == qmx_pkg::OP_WR_CFG) begin
                            cfg_nxt = shIn[7:0];
                            if (shIn[qmx_pkg::CFG_QUAD_BIT] && entry[3]) begin
                                quadMode_nxt = 1'b1;
                            end else if (!shIn[qmx_pkg::CFG_QUAD_BIT] && exitM[2]) begin
                                quadMode_nxt = 1'b0;
                            end
                        end else begin
                            vecr_nxt = shIn[7:0];
                            if (entry[4]) begin
                                quadMode_nxt = ~shIn[qmx_pkg::VECR_QUAD_BIT];
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (lk.sclkFall && st_r == qmx_pkg::ST_DOUT) begin
            if (quadMode_r) begin
                ioOut_nxt = outSh_r[7:4];
                ioOe_nxt  = 4'hF;
                outSh_nxt = {outSh_r[3:0], 4'h0};
            end else begin
                ioOut_nxt = {2'h0, outSh_r[7], 1'b0};
                ioOe_nxt  = 4'h2;
                outSh_nxt = {outSh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r       <= qmx_pkg::ST_IDLE;
            bitCnt_r   <= 5'h00;
            shift_r    <= 24'h0;
            outSh_r    <= 8'h00;
            op_r       <= 8'h00;
            quadMode_r <= 1'b0;
            cfg_r      <= qmx_pkg::CFG_RST;
            vecr_r     <= qmx_pkg::VECR_RST;
            rstArm_r   <= 1'b0;
            ioOut_r    <= 4'h0;
            ioOe_r     <= 4'h0;
        end else if (clkEn) begin
            st_r       <= st_nxt;
            bitCnt_r   <= bitCnt_nxt;
            shift_r    <= shift_nxt;
            outSh_r    <= outSh_nxt;
            op_r       <= op_nxt;
            quadMode_r <= quadMode_nxt;
            cfg_r      <= cfg_nxt;
            vecr_r     <= vecr_nxt;
            rstArm_r   <= rstArm_nxt;
            ioOut_r    <= ioOut_nxt;
            ioOe_r     <= ioOe_nxt;
        end
    end

    assign ioPinOut = ioOut_r;
    assign ioPinOe  = ioOe_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_xip_report: assert property ((avs_read && !waitReq_r && avs_address == qmx_pkg::IDX_PARAM)
        |-> avs_readdata[qmx_pkg::XIP_BIT] == param_r[qmx_pkg::XIP_BIT])
        else $error("Continuous-read support bit misreported");
    a_enter_alt: assert property ((clkEn && lk.csEnd && st_r == qmx_pkg::ST_DONE
        && op_r == qmx_pkg::OP_ENTER_ALT && entry[2]) |=> quadMode_r)
        else $error("35h did not enter quad mode");
    a_enter_gate: assert property ((clkEn && lk.csEnd && st_r == qmx_pkg::ST_DONE && !quadMode_r
        && op_r == qmx_pkg::OP_ENTER_QE && !entry[1] && !(entry[0] && qe_r)) |=> !quadMode_r)
        else $error("38h entered quad mode without an advertised method");
    a_exit_ff: assert property ((clkEn && lk.csEnd && st_r == qmx_pkg::ST_DONE
        && op_r == qmx_pkg::OP_EXIT_A && exitM[0]) |=> !quadMode_r)
        else $error("FFh did not leave quad mode");
    a_soft_reset: assert property ((clkEn && lk.csEnd && st_r == qmx_pkg::ST_DONE && rstArm_r
        && op_r == qmx_pkg::OP_RST) |=> (!quadMode_r && cfg_r == qmx_pkg::CFG_RST
        && vecr_r == qmx_pkg::VECR_RST))
        else $error("Soft reset kept volatile state");
    a_single_lane: assert property ((clkEn && lk.sclkRise && !lk.csStart && !lk.csEnd && !quadMode_r
        && st_r == qmx_pkg::ST_OPC && bitCnt_r < 5'h07) |=> bitCnt_r == $past(bitCnt_r) + 5'h01)
        else $error("Opcode not taken one bit per clock in 1-1-1 mode");
    a_bus_answer: assert property ((clkEn && (avs_read || avs_write) && waitReq_r)
        |=> !avs_waitrequest ##1 (avs_waitrequest || !clkEn))
        else $error("Bus answer not one cycle wide");
    a_out_lane: assert property ((ioOe_r != 4'h0) |-> (ioOe_r == (quadMode_r ? 4'hF : 4'h2)))
        else $error("Output lanes do not match the mode");
    a_oe_release: assert property ((!lk.csActive && !lk.csEnd) |-> (ioOe_r == 4'h0))
        else $error("Lanes driven outside a frame");

    c_enter_quad: cover property ($rose(quadMode_r));
    c_leave_quad: cover property ($fell(quadMode_r));
    c_cfg_read:   cover property (st_r == qmx_pkg::ST_DOUT && lk.sclkFall);
    c_reg_write:  cover property (avs_write && !waitReq_r);
endmodule

// >>> tb_qmx_seq.sv
`timescale 1ns/100ps
module tb_qmx_seq;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sclkPin;
    logic        csPinN;
    logic [3:0]  ioPinIn;
    logic [3:0]  ioPinOut;
    logic [3:0]  ioPinOe;
    logic [31:0] rv;
    logic [7:0]  rd;
    logic [31:0] wv;
    logic [3:0]  oeSeen;
    logic        clkEn = 1'b1;
    int          fails = 0;
    int          checks_done = 0;
    int          mParam = 'h2FF, mCfg = 0, mVecr = 'hFF, mQuad = 0, mQe = 0, mPrev = 0;
    // Rows: parameter word, opcode (00 = set parameter and control), addressed, data
    logic [26:0] steps [$] = '{
        {10'h011, 8'h00, 1'b0, 8'h00}, {10'h011, 8'h38, 1'b0, 8'h00},
        {10'h011, 8'h00, 1'b0, 8'h01}, {10'h011, 8'h38, 1'b0, 8'h00},
        {10'h011, 8'hFF, 1'b0, 8'h00}, {10'h011, 8'h38, 1'b0, 8'h00},
        {10'h022, 8'h00, 1'b0, 8'h00}, {10'h022, 8'h38, 1'b0, 8'h00},
        {10'h022, 8'hFF, 1'b0, 8'h00}, {10'h022, 8'hF5, 1'b0, 8'h00},
        {10'h008, 8'h00, 1'b0, 8'h00}, {10'h008, 8'h35, 1'b0, 8'h00},
        {10'h048, 8'h00, 1'b0, 8'h00}, {10'h048, 8'h35, 1'b0, 8'h00},
        {10'h048, 8'h66, 1'b0, 8'h00}, {10'h048, 8'h99, 1'b0, 8'h00},
        {10'h084, 8'h00, 1'b0, 8'h00}, {10'h084, 8'h65, 1'b1, 8'h00},
        {10'h084, 8'h71, 1'b1, 8'h40}, {10'h084, 8'h66, 1'b0, 8'h00},
        {10'h084, 8'h99, 1'b0, 8'h00}, {10'h084, 8'h71, 1'b1, 8'h40},
        {10'h084, 8'h65, 1'b1, 8'h00}, {10'h084, 8'h71, 1'b1, 8'h00},
        {10'h100, 8'h00, 1'b0, 8'h00}, {10'h100, 8'h65, 1'b0, 8'h00},
        {10'h100, 8'h61, 1'b0, 8'h7F}, {10'h100, 8'h65, 1'b0, 8'h00},
        {10'h100, 8'h61, 1'b0, 8'hFF}
    };

    always #5 clk_sys = ~clk_sys;
    always @(posedge sclkPin) oeSeen <= ioPinOe;

    qmx_seq qmx_seq_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sclkPin(sclkPin), .csPinN(csPinN), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe)
    );
    qmx_host_model qmx_host_model_inst (
        .sclkPin(sclkPin), .csPinN(csPinN), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input bit wr, input logic [1:0] a, input logic [31:0] wd, output logic [31:0] q);
        bit got = 1'b0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        while (!got) begin
            @(posedge clk_sys);
            got = (avs_waitrequest === 1'b0);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic status();
        bus(1'b0, qmx_pkg::IDX_STATUS, 32'h00000000, rv);
        check(rv & 32'h00FFFF01, {8'h00, mVecr[7:0], mCfg[7:0], 7'h00, mQuad[0]});
    endtask

    // One framed command; the reference state follows the advertised methods
    task automatic cmd(input logic [7:0] op, input bit ad, input logic [7:0] wd);
        logic [47:0] d;
        int          n;
        d = ad ? {op, qmx_pkg::CFG_ADDR, wd, 8'h00} : {op, wd, 32'h00000000};
        if (op == 8'h65) d[39-(ad ? 24 : 0) -: 8] = 8'($urandom);
        n = (op == 8'h65 || op == 8'h71) ? (ad ? 40 : 16) : (op == 8'h61 ? 16 : 8);
        qmx_host_model_inst.frame(d, n, mQuad[0], rd);
        if (op == 8'h65) check({24'h000000, rd}, ad ? mCfg : mVecr);
        if (op == 8'h65) check({28'h0000000, oeSeen}, mQuad[0] ? 32'h0000000F : 32'h00000002);
        case (op)
            8'h38: if (mParam[5] || (mParam[4] && mQe)) mQuad = 1;
            8'h35: if (mParam[6]) mQuad = 1;
            8'hFF: if (mParam[0]) mQuad = 0;
            8'hF5: if (mParam[1]) mQuad = 0;
            8'h71: begin
                mCfg = wd;
                if (mParam[7] && wd[6]) mQuad = 1;
                if (mParam[2] && !wd[6]) mQuad = 0;
            end
            8'h61: begin
                mVecr = wd;
                if (mParam[8]) mQuad = !wd[7];
            end
            8'h99: if (mPrev == 'h66) begin
                mQuad = 0;
                mCfg  = 0;
                mVecr = 'hFF;
            end
            default: ;
        endcase
        mPrev = op;
        status();
        check({28'h0000000, ioPinOe}, 32'h00000000);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rv = $urandom(35);
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        bus(1'b0, qmx_pkg::IDX_PARAM, 32'h00000000, rv);
        check(rv, 32'h000002FF);
        clkEn <= 1'b0;
        fork
            bus(1'b0, qmx_pkg::IDX_CTRL, 32'h00000000, rv);
            begin
                repeat (3 + $urandom % 4) @(posedge clk_sys);
                clkEn <= 1'b1;
            end
        join
        check(rv, 32'h00000000);
        bus(1'b0, 2'h3, 32'h00000000, rv);
        check(rv, 32'h00000000);
        bus(1'b1, qmx_pkg::IDX_STATUS, 32'hFFFFFFFF, rv);
        status();
        rd = 8'h00;
        wv = $urandom;
        bus(1'b1, qmx_pkg::IDX_PARAM, wv, rv);
        bus(1'b0, qmx_pkg::IDX_PARAM, 32'h00000000, rv);
        check(rv, {22'h000000, wv[9:0]});
        $display("Reset and register test done");
        foreach (steps[i]) begin
            if (steps[i][16:9] == 8'h00) begin
                mParam = steps[i][26:17];
                mQe    = steps[i][0];
                bus(1'b1, qmx_pkg::IDX_PARAM, {22'h000000, steps[i][26:17]}, rv);
                bus(1'b1, qmx_pkg::IDX_CTRL, {31'h00000000, steps[i][0]}, rv);
            end else begin
                cmd(steps[i][16:9], steps[i][8], steps[i][7:0]);
            end
            $display("Step %0d done", i);
        end
        finish_test();
    end

    initial begin
        #600000;
        fails++;
        $display("ERROR %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
